// [rtl/cpf_framer.sv]
// cyclic process data framer with apb register access
// Contract
// - with selector 127 the device enters compatibility mode by itself when the setup identity shows a replacement.
// - selector 128 forces compatibility mode and the legacy identity.
// - the mode is decided from the selector and identity exchanged at cyclic setup.
// - in compatibility mode status codes follow the 3.0 profile only.
// - each analog value goes out as four float bytes and one status byte.
// - bit 7 of the first byte of each value is the sign.
// - values are single precision floats with exponent bias 127, passed unchanged.
// - status follows 3.01 for generic identities or selector 1 with condensed status off.
// - status follows 3.02 for selector 1 with condensed status on.
// - with selector 127 the applied configuration identity chooses 3.01 or 3.02.
// - no more than five cyclic slots exist.
// - slots 1 to 4 carry analog inputs read by the master, slot 5 a display value it writes.
// - process temperature and internal reference temperature are selectable inputs.
// - device data sits in slot 0 and the channel setting blocks share slots 1 and 2.
// - input block bytes 0 to 3 hold the float and byte 4 the status.
//
// Our own choices: the APB slave port and the register addresses.
`default_nettype none
module cpf_framer
  import cpf_pkg::*;
#(
  parameter logic [15:0] MANUF_IDENT = 16'h0A5A, // arbitrary value
  parameter logic [15:0] LEGACY_IDENT = 16'h0B6B, // arbitrary value
  parameter logic [15:0] PROFILE_BASE = 16'h0C00 // arbitrary value
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured values
  input wire logic [31:0] proc_temp,
  input wire logic [31:0] ref_temp,
  // cyclic setup from the link engine
  input wire logic setup_valid,
  input wire logic [15:0] setup_ident,
  output logic [15:0] ident_out,
  // input data stream towards the master
  input wire logic cyc_req,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  // output data stream from the master
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  // display value and interrupt
  output logic [31:0] disp_value,
  output logic [7:0] disp_status,
  output logic irq
);
  cpf_state_t s_r, s_nxt;
  logic dec_compat;
  cpf_prof_t dec_prof;
  logic [2:0] dec_n_ai;
  logic [15:0] dec_ident;
  logic [1:0] ld_slot;
  logic [7:0] st_mapped;
  logic [31:0] ld_val;

  // decoder sees the fresh identity during the setup cycle itself
  // a selector write alone changes nothing until the master sets up again
  cpf_mode_dec #(
    .MANUF_IDENT(MANUF_IDENT),
    .LEGACY_IDENT(LEGACY_IDENT),
    .PROFILE_BASE(PROFILE_BASE)
  ) u_dec (
    .sel(s_r.sel),
    .cond_en(s_r.cond_en),
    .cfg_id(setup_valid ? setup_ident : s_r.cfg_id),
    .compat(dec_compat),
    .prof(dec_prof),
    .n_ai(dec_n_ai),
    .ident(dec_ident)
  );

  // slot whose value is captured next; stream slot 0 is cyclic slot 1, because slot 0 keeps the
  // device data and slots 1 and 2 the channel settings, all reached acyclically and never streamed
  assign ld_slot = s_r.busy ? s_r.slot + 2'd1 : 2'd0;

  // status of the slot being loaded, translated to the profile latched at setup
  cpf_status_map u_map (
    .raw(s_r.ai_st[ld_slot]),
    .prof(s_r.prof),
    .mapped(st_mapped)
  );

  // value source chosen per slot
  // a software value lets a slot carry something the link engine does not measure
  always_comb begin
    unique case (s_r.ai_sel[2*ld_slot +: 2])
      CPF_SRC_PROC: ld_val = proc_temp;
      CPF_SRC_REF: ld_val = ref_temp;
      default: ld_val = s_r.ai_val[ld_slot];
    endcase
  end

  // register map, one aligned word each:
  //   0x00 ctrl: [7:0] selector, [8] condensed_diag_enable, [9] frame enable
  //   0x04 mode, read only: [0] compat, [2:1] profile, [5:3] slot count
  //   0x04 mode, read only: [6] busy, [7] setup seen, [31:16] applied identity
  //   0x08 event status, write one to clear
  //   0x0C event mask of the same layout
  //   0x10 source per slot, two bits each: process, reference, software value
  //   0x14 and 0x18 last display value and its status, read only
  //   0x20 to 0x2C software values, 0x30 to 0x3C raw status codes of the four slots
  // writes to read-only words change nothing; only unmapped words answer with pslverr

  // read mux, decided in the setup phase so data is ready in the access phase
  function automatic logic [32:0] rd(input cpf_state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    // the two slot pages decode on the high nibble, the word within on bits 3:2
    if (a[7:4] == CPF_PAGE_AI_VAL) begin
      r[31:0] = s.ai_val[a[3:2]];
    end else if (a[7:4] == CPF_PAGE_AI_ST) begin
      r[31:0] = {24'h000000, s.ai_st[a[3:2]]};
    end else begin
      unique case (a)
        CPF_ADDR_CTRL: r[31:0] = {22'h000000, s.enable, s.cond_en, s.sel};
        CPF_ADDR_MODE: r[31:0] = {s.cfg_id, 8'h00, s.setup_ok, s.busy, s.n_ai, s.prof, s.compat};
        CPF_ADDR_IRQ_STAT: r[31:0] = {28'h0000000, s.irq_st};
        CPF_ADDR_IRQ_MASK: r[31:0] = {28'h0000000, s.irq_mask};
        CPF_ADDR_AI_SEL: r[31:0] = {24'h000000, s.ai_sel};
        CPF_ADDR_DISP_VAL: r[31:0] = s.disp_val;
        CPF_ADDR_DISP_ST: r[31:0] = {24'h000000, s.disp_st};
        default: r[32] = 1'b1;
      endcase
    end
    return r;
  endfunction

  // byte k of a five byte block: float high byte first, status last
  // the status byte closes the block, so the sign byte is always the first one out
  function automatic logic [7:0] blk_byte(input logic [31:0] v, input logic [7:0] st, input logic [2:0] k);
    logic [7:0] b;
    b = st;
    unique case (k)
      3'd0: b = v[31:24];
      3'd1: b = v[23:16];
      3'd2: b = v[15:8];
      3'd3: b = v[7:0];
      default: b = st;
    endcase
    return b;
  endfunction

  // next state
  always_comb begin
    logic [32:0] rres;
    logic wr;
    logic [CPF_IRQ_W-1:0] ev;
    logic [CPF_IRQ_W-1:0] clr;
    logic [2:0] ridx;
    logic refuse;
    rres = rd(s_r, paddr);
    refuse = cyc_req && (s_r.busy || !s_r.setup_ok || !s_r.enable || setup_valid);
    wr = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
    ev = '0;
    clr = '0;
    ridx = rx_sof ? 3'd0 : s_r.rx_cnt;
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;

    // apb setup phase: answer in the first access cycle
    // write cycles return zero so stale read data never looks fresh
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = rres[32];
      s_nxt.prdata = pwrite ? 32'h0000_0000 : rres[31:0];
    end

    // apb writes take effect at the completing edge
    // refused or unmapped writes never reach here, since wr needs a clean answer
    if (wr) begin
      if (paddr[7:4] == CPF_PAGE_AI_VAL) begin
        s_nxt.ai_val[paddr[3:2]] = pwdata;
      end else if (paddr[7:4] == CPF_PAGE_AI_ST) begin
        s_nxt.ai_st[paddr[3:2]] = pwdata[7:0];
      end else begin
        unique case (paddr)
          CPF_ADDR_CTRL: begin
            s_nxt.sel = pwdata[CPF_CTRL_SEL_LSB +: 8];
            s_nxt.cond_en = pwdata[CPF_CTRL_COND_BIT];
            s_nxt.enable = pwdata[CPF_CTRL_EN_BIT];
          end
          CPF_ADDR_IRQ_STAT: clr = pwdata[CPF_IRQ_W-1:0];
          CPF_ADDR_IRQ_MASK: s_nxt.irq_mask = pwdata[CPF_IRQ_W-1:0];
          CPF_ADDR_AI_SEL: s_nxt.ai_sel = pwdata[7:0];
          default: s_nxt.prdata = s_r.prdata;
        endcase
      end
    end

    // cyclic setup latches identity and mode; selector changes wait for the next setup
    // a setup in the middle of a frame applies to the slots still to come
    if (setup_valid) begin
      s_nxt.cfg_id = setup_ident;
      s_nxt.compat = dec_compat;
      s_nxt.prof = dec_prof;
      s_nxt.n_ai = dec_n_ai;
      s_nxt.ident = dec_ident;
      s_nxt.setup_ok = 1'b1;
      ev[CPF_IRQ_SETUP] = 1'b1;
    end

    // input frame: one five byte block per active slot, slots 1..4 in order
    // a refused request must not stall a frame in flight, or the sink would take one byte twice
    if (refuse) begin
      ev[CPF_IRQ_REFUSE] = 1'b1;
    end
    if (cyc_req && !refuse) begin
      s_nxt.busy = 1'b1;
      s_nxt.slot = 2'd0;
      s_nxt.bidx = 3'd0;
      s_nxt.sh_val = ld_val;
      s_nxt.sh_st = st_mapped;
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data = ld_val[31:24];
      s_nxt.tx_last = 1'b0;
    end else if (s_r.busy && s_r.tx_valid && tx_ready) begin
      if (s_r.bidx == CPF_LAST_BYTE) begin
        if ({1'b0, s_r.slot} + 3'd1 >= s_r.n_ai) begin
          s_nxt.busy = 1'b0;
          s_nxt.tx_valid = 1'b0;
          s_nxt.tx_last = 1'b0;
          ev[CPF_IRQ_FRAME] = 1'b1;
        end else begin
          // next slot: value and status are captured together so the pair always matches
          s_nxt.slot = ld_slot;
          s_nxt.bidx = 3'd0;
          s_nxt.sh_val = ld_val;
          s_nxt.sh_st = st_mapped;
          s_nxt.tx_data = ld_val[31:24];
        end
      end else begin
        s_nxt.bidx = s_r.bidx + 3'd1;
        s_nxt.tx_data = blk_byte(s_r.sh_val, s_r.sh_st, s_r.bidx + 3'd1);
        // tx_last rides on the final status byte of the last active slot
        s_nxt.tx_last = (s_r.bidx + 3'd1 == CPF_LAST_BYTE) && ({1'b0, s_r.slot} + 3'd1 >= s_r.n_ai);
      end
    end

    // display value from the master: four value bytes then status
    // a start-of-block mark realigns the count, so a cut block is dropped, never spliced
    if (rx_valid) begin
      if (ridx == CPF_LAST_BYTE) begin
        s_nxt.disp_val = s_r.rx_buf;
        s_nxt.disp_st = rx_data;
        s_nxt.rx_cnt = 3'd0;
        ev[CPF_IRQ_DISP] = 1'b1;
      end else begin
        s_nxt.rx_buf = {s_r.rx_buf[23:0], rx_data};
        s_nxt.rx_cnt = ridx + 3'd1;
      end
    end

    // sticky events: a new event outweighs a clear in the same cycle
    // bit 0 setup taken, bit 1 frame done, bit 2 display block in, bit 3 request refused
    s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
  end

  // state register; the reset branch loads constants only, the selector its factory code
  // so that a replacement device recognises its predecessor's master by itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.sel <= CPF_SEL_RST;
      s_r.ai_sel <= CPF_AI_SEL_RST;
      s_r.ai_st <= {CPF_NUM_AI{CPF_AI_ST_RST}};
      s_r.prof <= CPF_PROF_301;
      s_r.n_ai <= CPF_MAX_AI;
      s_r.ident <= MANUF_IDENT;
      s_r.enable <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  // every output is a flip-flop, so nothing combinational reaches the link or the bus
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign ident_out = s_r.ident;
  assign tx_data = s_r.tx_data;
  assign tx_valid = s_r.tx_valid;
  assign tx_last = s_r.tx_last;
  assign disp_value = s_r.disp_val;
  assign disp_status = s_r.disp_st;
  assign irq = s_r.irq;
endmodule
`default_nettype wire

// [rtl/cpf_pkg.sv]
// shared constants and types for the cyclic process data framer
`default_nettype none
package cpf_pkg;
  // apb register byte addresses
  localparam logic [7:0] CPF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CPF_ADDR_MODE = 8'h04;
  localparam logic [7:0] CPF_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] CPF_ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] CPF_ADDR_AI_SEL = 8'h10;
  localparam logic [7:0] CPF_ADDR_DISP_VAL = 8'h14;
  localparam logic [7:0] CPF_ADDR_DISP_ST = 8'h18;
  localparam logic [3:0] CPF_PAGE_AI_VAL = 4'h2;
  localparam logic [3:0] CPF_PAGE_AI_ST = 4'h3;
  // ctrl field positions
  localparam int CPF_CTRL_SEL_LSB = 0;
  localparam int CPF_CTRL_COND_BIT = 8;
  localparam int CPF_CTRL_EN_BIT = 9;
  // reset values
  localparam logic [7:0] CPF_SEL_RST = 8'h7F;
  localparam logic [7:0] CPF_AI_SEL_RST = 8'hE4;
  localparam logic [7:0] CPF_AI_ST_RST = 8'h80;
  // selector codes
  localparam logic [7:0] CPF_SEL_PROF4 = 8'h00;
  localparam logic [7:0] CPF_SEL_MANUF = 8'h01;
  localparam logic [7:0] CPF_SEL_AUTO = 8'h7F;
  localparam logic [7:0] CPF_SEL_LEGACY = 8'h80;
  localparam logic [7:0] CPF_SEL_PROF1 = 8'h81;
  localparam logic [7:0] CPF_SEL_PROF2 = 8'h82;
  localparam logic [7:0] CPF_SEL_PROF3 = 8'h83;
  // frame layout
  localparam int CPF_NUM_AI = 4;
  localparam logic [2:0] CPF_LAST_BYTE = 3'd4;
  localparam logic [2:0] CPF_MAX_AI = 3'd4;
  // value source per slot
  localparam logic [1:0] CPF_SRC_PROC = 2'd0;
  localparam logic [1:0] CPF_SRC_REF = 2'd1;
  // interrupt bit positions
  localparam int CPF_IRQ_SETUP = 0;
  localparam int CPF_IRQ_FRAME = 1;
  localparam int CPF_IRQ_DISP = 2;
  localparam int CPF_IRQ_REFUSE = 3;
  localparam int CPF_IRQ_W = 4;
  // status codes
  localparam logic [7:0] CPF_ST_GOOD = 8'h80;
  localparam logic [7:0] CPF_ST_BAD = 8'h00;
  localparam logic [1:0] CPF_Q_BAD = 2'b00;
  localparam logic [1:0] CPF_Q_GOOD_NC = 2'b10;

  typedef enum logic [1:0] {CPF_PROF_30, CPF_PROF_301, CPF_PROF_302} cpf_prof_t;

  typedef struct packed {
    logic [7:0] sel;
    logic cond_en;
    logic enable;
    logic [7:0] ai_sel;
    logic [CPF_NUM_AI-1:0][31:0] ai_val;
    logic [CPF_NUM_AI-1:0][7:0] ai_st;
    logic [CPF_IRQ_W-1:0] irq_st;
    logic [CPF_IRQ_W-1:0] irq_mask;
    logic irq;
    logic compat;
    cpf_prof_t prof;
    logic [2:0] n_ai;
    logic [15:0] cfg_id;
    logic [15:0] ident;
    logic setup_ok;
    logic busy;
    logic [1:0] slot;
    logic [2:0] bidx;
    logic [31:0] sh_val;
    logic [7:0] sh_st;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic [2:0] rx_cnt;
    logic [31:0] rx_buf;
    logic [31:0] disp_val;
    logic [7:0] disp_st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpf_state_t;
endpackage
`default_nettype wire

// [rtl/cpf_mode_dec.sv]
// decodes selector and applied configuration identity into operating mode
`default_nettype none
module cpf_mode_dec
  import cpf_pkg::*;
#(
  parameter logic [15:0] MANUF_IDENT = 16'h0A5A, // arbitrary value
  parameter logic [15:0] LEGACY_IDENT = 16'h0B6B, // arbitrary value
  parameter logic [15:0] PROFILE_BASE = 16'h0C00 // arbitrary value
) (
  // selection
  input wire logic [7:0] sel,
  input wire logic cond_en,
  input wire logic [15:0] cfg_id,
  // decoded mode
  output logic compat,
  output cpf_prof_t prof,
  output logic [2:0] n_ai,
  output logic [15:0] ident
);
  logic prof_id;
  logic [1:0] prof_low;

  // profile identities differ from the base in the two low bits only
  assign prof_id = (cfg_id[15:2] == PROFILE_BASE[15:2]);
  assign prof_low = cfg_id[1:0];

  // mode table, evaluated against the identity seen at setup
  always_comb begin
    compat = 1'b0;
    prof = CPF_PROF_301;
    n_ai = CPF_MAX_AI;
    ident = MANUF_IDENT;
    unique case (sel)
      CPF_SEL_LEGACY: begin
        compat = 1'b1;
        prof = CPF_PROF_30;
        ident = LEGACY_IDENT;
      end
      CPF_SEL_AUTO: begin
        if (cfg_id == LEGACY_IDENT) begin
          compat = 1'b1;
          prof = CPF_PROF_30;
          ident = LEGACY_IDENT;
        end else if (prof_id) begin
          prof = CPF_PROF_301;
          n_ai = (prof_low == 2'd3) ? CPF_MAX_AI : {1'b0, prof_low} + 3'd1;
          ident = cfg_id;
        end else begin
          prof = CPF_PROF_302;
        end
      end
      CPF_SEL_MANUF: prof = cond_en ? CPF_PROF_302 : CPF_PROF_301;
      CPF_SEL_PROF4: ident = {PROFILE_BASE[15:2], 2'd3};
      CPF_SEL_PROF1: begin
        n_ai = 3'd1;
        ident = {PROFILE_BASE[15:2], 2'd0};
      end
      CPF_SEL_PROF2: begin
        n_ai = 3'd2;
        ident = {PROFILE_BASE[15:2], 2'd1};
      end
      CPF_SEL_PROF3: begin
        n_ai = 3'd3;
        ident = {PROFILE_BASE[15:2], 2'd2};
      end
      default: prof = CPF_PROF_301;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/cpf_status_map.sv]
// maps a raw status code to the code set of the active profile
`default_nettype none
module cpf_status_map
  import cpf_pkg::*;
(
  // raw code and profile
  input wire logic [7:0] raw,
  input wire cpf_prof_t prof,
  // translated code
  output logic [7:0] mapped
);
  // older profiles know no condensed sub-status; fold good ones onto plain good, and in 3.0 also bad ones onto plain bad
  always_comb begin
    mapped = raw;
    if (prof != CPF_PROF_302) begin
      if (raw[7:6] == CPF_Q_GOOD_NC && raw[5:2] != 4'h0) begin
        mapped = CPF_ST_GOOD | {6'h00, raw[1:0]};
      end
      if (prof == CPF_PROF_30 && raw[7:6] == CPF_Q_BAD && raw[5]) begin
        mapped = CPF_ST_BAD | {6'h00, raw[1:0]};
      end
    end
  end
endmodule
`default_nettype wire

// [bench/cpf_framer_sva.sv]
// port-level assertion checker for the cyclic process data framer
`default_nettype none
module cpf_framer_sva (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // setup and streams
  input wire logic setup_valid,
  input wire logic [15:0] ident_out,
  input wire logic cyc_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  input wire logic [31:0] disp_value,
  input wire logic [7:0] disp_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one display block sent back to back
  sequence disp_block;
    rx_valid && rx_sof ##1 (rx_valid && !rx_sof) [*4];
  endsequence
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup cycle");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_UNMAPPED: assert property (psel && !penable && paddr == 8'h1C |=> pready && pslverr)
    else $error("unmapped access not refused");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("stalled byte changed");
  AST_TX_GAPLESS: assert property (tx_valid && tx_ready && !tx_last |=> tx_valid)
    else $error("frame broke off early");
  AST_TX_END: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("stream ran past last byte");
  AST_TX_START: assert property ($rose(tx_valid) |-> $past(cyc_req))
    else $error("frame started without request");
  AST_IDENT_STANDS: assert property (!setup_valid |=> $stable(ident_out))
    else $error("identity changed without setup");
  AST_DISP_VALUE: assert property (disp_block |=> disp_value == {$past(rx_data, 5), $past(rx_data, 4),
    $past(rx_data, 3), $past(rx_data, 2)} && disp_status == $past(rx_data))
    else $error("display value not assembled");
endmodule
bind cpf_framer cpf_framer_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .setup_valid, .ident_out, .cyc_req, .tx_data, .tx_valid, .tx_last, .tx_ready, .rx_valid, .rx_sof,
  .rx_data, .disp_value, .disp_status);
`default_nettype wire

// [bench/cpf_master_model.sv]
// behavioural cyclic bus master facing the framer's link side
`default_nettype none
module cpf_master_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // setup and request
  output var logic setup_valid,
  output var logic [15:0] setup_ident,
  output var logic cyc_req,
  // input stream from the device
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output var logic tx_ready,
  // display stream to the device
  output var logic rx_valid,
  output var logic rx_sof,
  output var logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic [7:0] rxq[$];
  initial begin
    setup_valid = 1'b0;
    setup_ident = 16'h0000;
    cyc_req = 1'b0;
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'hA5;
  end
  // slow sink drops ready every other cycle to exercise the hold
  always @(posedge pclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (presetn && tx_valid && tx_ready) rxq.push_back(tx_data);
  end
  // identity applied at cyclic setup, line scrambled afterwards
  task automatic do_setup(input logic [15:0] id);
    setup_valid <= 1'b1;
    setup_ident <= id;
    @(posedge pclk);
    setup_valid <= 1'b0;
    setup_ident <= ~id;
    @(posedge pclk);
  endtask
  task automatic request();
    cyc_req <= 1'b1;
    @(posedge pclk);
    cyc_req <= 1'b0;
    @(posedge pclk);
  endtask
  // four value bytes high first, then the status byte
  task automatic send_disp(input logic [31:0] v, input logic [7:0] s);
    for (int i = 0; i < 5; i++) begin
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= (i < 4) ? v[31 - 8 * i -: 8] : s;
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_data <= ~s;
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the cyclic process data framer
`default_nettype none
module testbench
  import cpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LEG_ID = 16'h0B6B; // arbitrary value
  localparam logic [15:0] PRF_ID = 16'h0C00; // arbitrary value
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, proc_temp = 32'hC0F0_0000, ref_temp = 32'h40F0_0000;
  logic [31:0] prdata, disp_value, rd;
  logic pready, pslverr, tx_valid, tx_last, tx_ready, irq, setup_valid, cyc_req, rx_valid, rx_sof, err;
  logic [7:0] tx_data, rx_data, disp_status;
  logic [15:0] ident_out, setup_ident;
  logic [7:0] fr [15] = '{8'hC0, 8'hF0, 8'h00, 8'h00, 8'h80, 8'h40, 8'hF0, 8'h00, 8'h00, 8'h80,
    8'h41, 8'h20, 8'h00, 8'h00, 8'h82};
  int n_mismatch = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  cpf_framer #(.LEGACY_IDENT(LEG_ID), .PROFILE_BASE(PRF_ID)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .proc_temp, .ref_temp, .setup_valid,
    .setup_ident, .ident_out, .cyc_req, .tx_data, .tx_valid, .tx_last, .tx_ready, .rx_valid, .rx_sof,
    .rx_data, .disp_value, .disp_status, .irq);
  cpf_master_model u_mst (.pclk, .presetn, .setup_valid, .setup_ident, .cyc_req, .tx_data, .tx_valid,
    .tx_last, .tx_ready, .rx_valid, .rx_sof, .rx_data);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // sc holds the condensed flag above the selector
  task automatic mode(input logic [8:0] sc, input logic [15:0] id, input logic [31:0] m, input logic [31:0] e);
    apb(1'b1, CPF_ADDR_CTRL, {22'h0, 1'b1, sc});
    u_mst.do_setup(id);
    apb(1'b0, CPF_ADDR_MODE, 32'h0);
    chk("mode", e, rd & m);
  endtask
  // waits until the master model holds n bytes; running out counts as a mismatch
  task automatic wait_bytes(input int n);
    int t;
    t = 0;
    while (u_mst.rxq.size() < n && t < 200) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 200) n_mismatch++;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl", CPF_ADDR_CTRL, 32'h0000_027F);
    rchk("ai_sel", CPF_ADDR_AI_SEL, 32'h0000_00E4);
    rchk("ai_st", 8'h30, 32'h0000_0080);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    u_mst.request();
    repeat (8) @(posedge pclk);
    rchk("refused", CPF_ADDR_IRQ_STAT, 32'h8);
    chk("nothing sent", 32'h0, 32'(u_mst.rxq.size()));
    $display("test reset done");
    mode(9'h07F, LEG_ID, 32'h7, 32'h1);
    chk("ident", {16'h0, LEG_ID}, {16'h0, ident_out});
    mode(9'h080, 16'h1234, 32'h7, 32'h1);
    chk("ident", {16'h0, LEG_ID}, {16'h0, ident_out});
    mode(9'h07F, PRF_ID + 16'h1, 32'h3F, 32'h12);
    mode(9'h07F, 16'h1234, 32'h3F, 32'h24);
    mode(9'h000, 16'h1234, 32'h3F, 32'h22);
    mode(9'h081, 16'h1234, 32'h3F, 32'h0A);
    mode(9'h083, 16'h1234, 32'h3F, 32'h1A);
    mode(9'h001, 16'h1234, 32'h7, 32'h2);
    mode(9'h101, 16'h1234, 32'h7, 32'h4);
    mode(9'h082, 16'h1234, 32'h3F, 32'h12);
    $display("test mode done");
    apb(1'b1, CPF_ADDR_IRQ_STAT, 32'hF);
    u_mst.slow = 1'b1;
    u_mst.request();
    u_mst.request();
    wait_bytes(10);
    for (int i = 0; i < 10; i++) chk("frame byte", {24'h0, fr[i]}, {24'h0, u_mst.rxq[i]});
    rchk("frame irq", CPF_ADDR_IRQ_STAT, 32'hA);
    chk("frame length", 32'd10, 32'(u_mst.rxq.size()));
    $display("test frame done");
    apb(1'b1, CPF_ADDR_IRQ_STAT, 32'hF);
    apb(1'b1, CPF_ADDR_IRQ_MASK, 32'h4);
    u_mst.send_disp(32'hC1A8_0000, 8'h4C);
    repeat (2) @(posedge pclk);
    chk("disp value", 32'hC1A8_0000, disp_value);
    chk("disp status", 32'h4C, {24'h0, disp_status});
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, CPF_ADDR_IRQ_STAT, 32'h4);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test display done");
    apb(1'b1, CPF_ADDR_AI_SEL, 32'h0000_0002);
    apb(1'b1, 8'h20, 32'h4120_0000);
    apb(1'b1, 8'h30, 32'h0000_008E);
    mode(9'h081, 16'h1234, 32'h3F, 32'h0A);
    u_mst.request();
    wait_bytes(15);
    for (int i = 10; i < 15; i++) chk("fold byte", {24'h0, fr[i]}, {24'h0, u_mst.rxq[i]});
    apb(1'b1, CPF_ADDR_IRQ_STAT, 32'hF);
    apb(1'b1, CPF_ADDR_CTRL, 32'h0000_0081);
    u_mst.request();
    rchk("off refused", CPF_ADDR_IRQ_STAT, 32'h8);
    chk("off silent", 32'd15, 32'(u_mst.rxq.size()));
    $display("test fold done");
    final_report();
  end
endmodule
`default_nettype wire
